// *** design/radio_spi_pkg.sv ***
// Purpose: Shared constants for the radio SPI host interface
// Assumes: 8-bit special-function register port
// Notes:   Offsets are byte addresses on that port
package radio_spi_pkg;
    // Register addresses
    localparam logic [7:0] ADDR_CFG  = 8'hE4;
    localparam logic [7:0] ADDR_MASK = 8'hE5;
    localparam logic [7:0] ADDR_STAT = 8'hE6;
    localparam logic [7:0] ADDR_DATA = 8'hE7;
    localparam logic [7:0] ADDR_CTRL = 8'hE8;
    // Reset values
    localparam logic [6:0] RST_CFG  = 7'h01;
    localparam logic [3:0] RST_MASK = 4'hF;
    localparam logic [3:0] RST_STAT = 4'h3;
    localparam logic [7:0] RST_DATA = 8'h00;
    localparam logic [2:0] RST_CTRL = 3'h2;
    // Status and mask bit positions
    localparam int BIT_RX_FULL  = 3;
    localparam int BIT_RX_AVAIL = 2;
    localparam int BIT_TX_EMPTY = 1;
    localparam int BIT_TX_SPACE = 0;
    // Control bit positions
    localparam int CTRL_CLKEN = 2;
    localparam int CTRL_SSN   = 1;
    localparam int CTRL_CE    = 0;
    // Sizes
    localparam int FIFO_DEPTH = 2;
    localparam int BYTE_W     = 8;
    localparam int STAT_W     = 4;
    localparam logic [2:0] LAST_BIT = 3'h7;
    // Shifter states
    typedef enum logic [1:0] {
        SH_IDLE = 2'b00,
        SH_LOW  = 2'b01,
        SH_HIGH = 2'b10
    } shift_state_t;
endpackage : radio_spi_pkg

// *** design/spi_xfer_if.sv ***
// Purpose: Byte handshake between system and link domains
// Assumes: Toggle request and toggle done, data held stable
// Notes:   No clock of its own
`timescale 1ns/1ps
interface spi_xfer_if;
    logic       reqTgl;
    logic [7:0] txByte;
    logic       doneTgl;
    logic [7:0] rxByte;
    modport sys  (output reqTgl, output txByte, input doneTgl, input rxByte);
    modport link (input reqTgl, input txByte, output doneTgl, output rxByte);
endinterface : spi_xfer_if

// *** design/spi_shift_engine.sv ***
// Purpose: Serial byte shifter on the link clock
// Assumes: Mode 0, sck half period is one link clock
// Notes:   Request and done cross as toggles
`timescale 1ns/1ps
module spi_shift_engine (
    input  wire logic clk_link,
    input  wire logic rst_n,
    input  wire logic miso,
    spi_xfer_if.link  xfer,
    output logic      sck,
    output logic      mosi
);
    logic rstMeta_r, rstSync_r;
    logic reqMeta_r, reqSync_r, reqSeen_r;
    radio_spi_pkg::shift_state_t state_r;
    logic [2:0] bitCnt_r;
    logic [7:0] shift_r;
    logic       doneTgl_r;
    logic [7:0] rxByte_r;
    logic       newReq;

    ////////////////////////////////////////////////////////////////
    // Reset synchroniser on the link clock
    always_ff @(posedge clk_link) begin
        rstMeta_r <= rst_n;
        rstSync_r <= rstMeta_r;
    end

    assign newReq = (reqSync_r != reqSeen_r);
    assign xfer.doneTgl = doneTgl_r;
    assign xfer.rxByte  = rxByte_r;

    ////////////////////////////////////////////////////////////////
    // Shift sequencer, MSB first, sample on rising sck
    always_ff @(posedge clk_link) begin
        if (!rstSync_r) begin
            reqMeta_r <= 1'b0;
            reqSync_r <= 1'b0;
            reqSeen_r <= 1'b0;
            state_r   <= radio_spi_pkg::SH_IDLE;
            bitCnt_r  <= 3'h0;
            shift_r   <= 8'h00;
            sck       <= 1'b0;
            mosi      <= 1'b0;
            doneTgl_r <= 1'b0;
            rxByte_r  <= 8'h00;
        end else begin
            reqMeta_r <= xfer.reqTgl;
            reqSync_r <= reqMeta_r;
            case (state_r)
                radio_spi_pkg::SH_IDLE: begin
                    if (newReq) begin
                        reqSeen_r <= reqSync_r;
                        shift_r   <= xfer.txByte;
                        mosi      <= xfer.txByte[7]; // [RULE17]
                        bitCnt_r  <= 3'h0;
                        state_r   <= radio_spi_pkg::SH_LOW;
                    end
                end
                radio_spi_pkg::SH_LOW: begin
                    sck     <= 1'b1;
                    shift_r <= {shift_r[6:0], miso};
                    state_r <= radio_spi_pkg::SH_HIGH;
                end
                radio_spi_pkg::SH_HIGH: begin
                    sck <= 1'b0;
                    if (bitCnt_r == radio_spi_pkg::LAST_BIT) begin
                        rxByte_r  <= shift_r;
                        doneTgl_r <= ~doneTgl_r;
                        state_r   <= radio_spi_pkg::SH_IDLE;
                    end else begin
                        bitCnt_r <= bitCnt_r + 3'h1;
                        mosi     <= shift_r[7]; // [RULE17]
                        state_r  <= radio_spi_pkg::SH_LOW;
                    end
                end
                default: state_r <= radio_spi_pkg::SH_IDLE;
            endcase
        end
    end

    // First bit out is the byte's top bit
    property p_msb_first;
        @(posedge clk_link) disable iff (!rstSync_r)
        (state_r == radio_spi_pkg::SH_IDLE && newReq) |=> (mosi == $past(xfer.txByte[7]));
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("first bit not msb"); // [RULE17]
endmodule : spi_shift_engine

// *** design/radio_spi_host_interface.sv ***
// Purpose: Radio SPI master with FIFOs, status, mask and control
// Assumes: Special-function register port on clk_sys, link clock in
// Notes:   One byte in flight at a time across the link domain
//
// Summary of operation
// RULE1: Four mask bits, one suppresses, reset ones
// RULE2: Interrupt on any active unmasked source
// RULE3: Status bit 3 means receive FIFO full
// RULE4: Status bit 2 means receive byte waiting
// RULE5: Status bit 1 means transmit FIFO empty
// RULE6: Status bit 0 means transmit slot free
// RULE7: Flags live, not sticky, reset 0x03
// RULE8: Data write pushes, read pops, two deep
// RULE9: Software respects slot and data-ready flags
// RULE10: Control bit 2 gates radio clock
// RULE11: Control bit 1 drives slave select low-active
// RULE12: Control bit 0 drives chip enable
// RULE13: Software keeps reserved config at 0x01
// RULE14: Chip enable toggle restarts same packet
// RULE15: Commands start with slave select low
// RULE16: First returned byte is radio status
// RULE17: Bytes shift most significant bit first
// RULE18: Shift when transmit waiting and receive room
// RULE19: Interrupt is OR of unmasked flags
`timescale 1ns/1ps
module radio_spi_host_interface #(
    parameter int DEPTH = radio_spi_pkg::FIFO_DEPTH
) (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       clk_link,
    input  wire logic [7:0] sfrAddr,
    input  wire logic       sfrWrEn,
    input  wire logic       sfrRdEn,
    input  wire logic [7:0] sfrWrData,
    output logic      [7:0] sfrRdData,
    input  wire logic       miso,
    output logic            sck,
    output logic            mosi,
    output logic            slaveSelectN,
    output logic            chipEnable,
    output logic            radioClkEn,
    output logic            irq
);
    localparam int IDX_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;
    localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

    spi_xfer_if xfer ();

    // Register state
    logic [6:0]        cfgReg_r;
    logic [3:0]        maskReg_r;
    logic [2:0]        ctrlReg_r;
    logic [3:0]        flags_r;
    logic [7:0]        sfrRdData_r;
    logic              irq_r;
    // FIFO state
    logic [7:0]        txMem_r [DEPTH];
    logic [7:0]        rxMem_r [DEPTH];
    logic [IDX_W-1:0]  txRdIdx_r, txWrIdx_r;
    logic [IDX_W-1:0]  rxRdIdx_r, rxWrIdx_r;
    logic [CNT_W-1:0]  txCount_r, rxCount_r;
    logic [CNT_W-1:0]  txCount_nxt, rxCount_nxt;
    // Crossing state
    logic              busy_r;
    logic              reqTgl_r;
    logic [7:0]        txByte_r;
    logic              doneMeta_r, doneSync_r, doneSeen_r;
    // Decode
    logic              selCfg, selMask, selStat, selData, selCtrl;
    logic              txPush, txPop, rxPush, rxPop, startXfer;
    logic              doneEvt_w;
    logic [3:0]        flags_nxt;
    logic [3:0]        mask_nxt;
    logic [7:0]        rdData_nxt;
    logic [IDX_W-1:0]  txRdIdxInc, txWrIdxInc, rxRdIdxInc, rxWrIdxInc;

    ////////////////////////////////////////////////////////////////
    // Address decode
    assign selCfg  = (sfrAddr == radio_spi_pkg::ADDR_CFG);
    assign selMask = (sfrAddr == radio_spi_pkg::ADDR_MASK);
    assign selStat = (sfrAddr == radio_spi_pkg::ADDR_STAT);
    assign selData = (sfrAddr == radio_spi_pkg::ADDR_DATA);
    assign selCtrl = (sfrAddr == radio_spi_pkg::ADDR_CTRL);

    // FIFO strobes; full writes and empty reads are dropped
    assign txPush    = sfrWrEn && selData && (txCount_r != CNT_FULL); // [RULE8]
    assign rxPop     = sfrRdEn && selData && (rxCount_r != CNT_ZERO); // [RULE8]
    assign doneEvt_w = (doneSync_r != doneSeen_r);
    assign rxPush    = doneEvt_w;
    // Room counted before start so the returning byte always fits
    assign startXfer = !busy_r && (txCount_r != CNT_ZERO)
                       && (rxCount_r != CNT_FULL);                     // [RULE18]
    assign txPop     = startXfer;

    // Index wrap
    function automatic logic [IDX_W-1:0] idxInc(input logic [IDX_W-1:0] i);
        idxInc = (i == IDX_W'(DEPTH - 1)) ? '0 : i + IDX_W'(1);
    endfunction : idxInc
    assign txRdIdxInc = idxInc(txRdIdx_r);
    assign txWrIdxInc = idxInc(txWrIdx_r);
    assign rxRdIdxInc = idxInc(rxRdIdx_r);
    assign rxWrIdxInc = idxInc(rxWrIdx_r);

    // Next occupancy
    assign txCount_nxt = txCount_r + (txPush ? CNT_ONE : CNT_ZERO)
                         - (txPop ? CNT_ONE : CNT_ZERO);
    assign rxCount_nxt = rxCount_r + (rxPush ? CNT_ONE : CNT_ZERO)
                         - (rxPop ? CNT_ONE : CNT_ZERO);

    // Live flags from next occupancy, never latched
    assign flags_nxt[radio_spi_pkg::BIT_RX_FULL]  = (rxCount_nxt == CNT_FULL);  // [RULE3]
    assign flags_nxt[radio_spi_pkg::BIT_RX_AVAIL] = (rxCount_nxt != CNT_ZERO);  // [RULE4]
    assign flags_nxt[radio_spi_pkg::BIT_TX_EMPTY] = (txCount_nxt == CNT_ZERO);  // [RULE5]
    assign flags_nxt[radio_spi_pkg::BIT_TX_SPACE] = (txCount_nxt != CNT_FULL);  // [RULE6]
    assign mask_nxt = (sfrWrEn && selMask) ? sfrWrData[3:0] : maskReg_r;       // [RULE1]

    // Read mux; reserved bits read zero
    assign rdData_nxt =
        selCfg  ? {1'b0, cfgReg_r} :
        selMask ? {4'h0, maskReg_r} :
        selStat ? {4'h0, flags_r} :
        selData ? (rxCount_r != CNT_ZERO ? rxMem_r[rxRdIdx_r] : radio_spi_pkg::RST_DATA) :
        selCtrl ? {5'h00, ctrlReg_r} : 8'h00;

    // Outputs straight from flops
    assign sfrRdData    = sfrRdData_r;
    assign irq          = irq_r;
    assign slaveSelectN = ctrlReg_r[radio_spi_pkg::CTRL_SSN];   // [RULE11]
    assign chipEnable   = ctrlReg_r[radio_spi_pkg::CTRL_CE];    // [RULE12]
    assign radioClkEn   = ctrlReg_r[radio_spi_pkg::CTRL_CLKEN]; // [RULE10]
    assign xfer.reqTgl  = reqTgl_r;
    assign xfer.txByte  = txByte_r;

    ////////////////////////////////////////////////////////////////
    // Configuration, mask and control registers
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cfgReg_r  <= radio_spi_pkg::RST_CFG;
            maskReg_r <= radio_spi_pkg::RST_MASK; // [RULE1]
            ctrlReg_r <= radio_spi_pkg::RST_CTRL;
        end else begin
            maskReg_r <= mask_nxt;
            if (sfrWrEn && selCfg)
                cfgReg_r <= sfrWrData[6:0];
            // Chip enable toggles pass straight out for a restart
            if (sfrWrEn && selCtrl)
                ctrlReg_r <= sfrWrData[2:0]; // [RULE14] [RULE10] [RULE11] [RULE12]
        end
    end

    // Status, interrupt and read data
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            flags_r     <= radio_spi_pkg::RST_STAT; // [RULE7]
            irq_r       <= 1'b0;
            sfrRdData_r <= radio_spi_pkg::RST_DATA;
        end else begin
            flags_r     <= flags_nxt;                // [RULE7]
            irq_r       <= |(flags_nxt & ~mask_nxt); // [RULE2] [RULE19]
            if (sfrRdEn)
                sfrRdData_r <= rdData_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Transmit FIFO
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            txRdIdx_r <= '0;
            txWrIdx_r <= '0;
            txCount_r <= CNT_ZERO;
        end else begin
            txCount_r <= txCount_nxt;
            if (txPush)
                txWrIdx_r <= txWrIdxInc;
            if (txPop)
                txRdIdx_r <= txRdIdxInc;
        end
    end

    // Transmit storage
    always_ff @(posedge clk_sys) begin
        if (txPush)
            txMem_r[txWrIdx_r] <= sfrWrData; // [RULE8]
    end

    // Receive FIFO; first byte of a command is radio status
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rxRdIdx_r <= '0;
            rxWrIdx_r <= '0;
            rxCount_r <= CNT_ZERO;
        end else begin
            rxCount_r <= rxCount_nxt;
            if (rxPush)
                rxWrIdx_r <= rxWrIdxInc; // [RULE16]
            if (rxPop)
                rxRdIdx_r <= rxRdIdxInc;
        end
    end

    // Receive storage, byte stable while done toggle settles
    always_ff @(posedge clk_sys) begin
        if (rxPush)
            rxMem_r[rxWrIdx_r] <= xfer.rxByte; // [RULE16]
    end

    ////////////////////////////////////////////////////////////////
    // Request launch and done synchroniser
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            busy_r     <= 1'b0;
            reqTgl_r   <= 1'b0;
            txByte_r   <= radio_spi_pkg::RST_DATA;
            doneMeta_r <= 1'b0;
            doneSync_r <= 1'b0;
            doneSeen_r <= 1'b0;
        end else begin
            doneMeta_r <= xfer.doneTgl;
            doneSync_r <= doneMeta_r;
            if (doneEvt_w)
                doneSeen_r <= doneSync_r;
            if (startXfer) begin
                busy_r   <= 1'b1;               // [RULE18]
                reqTgl_r <= ~reqTgl_r;
                txByte_r <= txMem_r[txRdIdx_r];
            end else if (doneEvt_w) begin
                busy_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Serial engine on the link clock
    spi_shift_engine u_shift (
        .clk_link (clk_link),
        .rst_n    (rst_n),
        .miso     (miso),
        .xfer     (xfer.link),
        .sck      (sck),
        .mosi     (mosi)
    );

    ////////////////////////////////////////////////////////////////
    // Checks; a byte round trip is two syncs plus 16 link clocks, about 57 to 59 cycles
    property p_mask_write;
        @(posedge clk_sys) disable iff (!rst_n)
        (sfrWrEn && selMask) |=> (maskReg_r == $past(sfrWrData[3:0]));
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("mask not written"); // [RULE1]

    property p_irq_gate;
        @(posedge clk_sys) disable iff (!rst_n)
        irq_r == |(flags_r & ~maskReg_r);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq mismatch"); // [RULE19]

    property p_irq_masked;
        @(posedge clk_sys) disable iff (!rst_n)
        (maskReg_r == radio_spi_pkg::RST_MASK) |-> !irq_r;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("irq when masked"); // [RULE2]

    property p_rx_full;
        @(posedge clk_sys) disable iff (!rst_n)
        flags_r[radio_spi_pkg::BIT_RX_FULL] == (rxCount_r == CNT_FULL);
    endproperty
    a_rx_full: assert property (p_rx_full) else $error("rx full flag wrong"); // [RULE3]

    property p_rx_avail;
        @(posedge clk_sys) disable iff (!rst_n)
        flags_r[radio_spi_pkg::BIT_RX_AVAIL] == (rxCount_r != CNT_ZERO);
    endproperty
    a_rx_avail: assert property (p_rx_avail) else $error("rx avail flag wrong"); // [RULE4]

    property p_tx_flags;
        @(posedge clk_sys) disable iff (!rst_n)
        (flags_r[radio_spi_pkg::BIT_TX_EMPTY] == (txCount_r == CNT_ZERO))
        && (flags_r[radio_spi_pkg::BIT_TX_SPACE] == (txCount_r != CNT_FULL));
    endproperty
    a_tx_flags: assert property (p_tx_flags) else $error("tx flags wrong"); // [RULE5]

    property p_full_clears;
        @(posedge clk_sys) disable iff (!rst_n)
        (rxPop && !rxPush && rxCount_r == CNT_FULL)
        |=> !flags_r[radio_spi_pkg::BIT_RX_FULL];
    endproperty
    a_full_clears: assert property (p_full_clears) else $error("full stuck"); // [RULE7]

    property p_push_one;
        @(posedge clk_sys) disable iff (!rst_n)
        (txPush && txCount_r == CNT_ZERO) |=> (txCount_r == CNT_ONE);
    endproperty
    a_push_one: assert property (p_push_one) else $error("tx push lost"); // [RULE8]

    property p_ctrl_out;
        @(posedge clk_sys) disable iff (!rst_n)
        (sfrWrEn && selCtrl) |=> (slaveSelectN == $past(sfrWrData[1]))
        && (chipEnable == $past(sfrWrData[0])) && (radioClkEn == $past(sfrWrData[2]));
    endproperty
    a_ctrl_out: assert property (p_ctrl_out) else $error("control pins wrong"); // [RULE11]

    property p_start;
        @(posedge clk_sys) disable iff (!rst_n)
        startXfer |=> busy_r && (reqTgl_r != $past(reqTgl_r));
    endproperty
    a_start: assert property (p_start) else $error("shift not started"); // [RULE18]

    property p_byte_back;
        @(posedge clk_sys) disable iff (!rst_n)
        startXfer |-> ##[50:70] doneEvt_w;
    endproperty
    a_byte_back: assert property (p_byte_back) else $error("byte never returned"); // [RULE16]

    c_tx_full: cover property (@(posedge clk_sys) txCount_r == CNT_FULL);
    c_rx_full: cover property (@(posedge clk_sys) rxCount_r == CNT_FULL);
    c_irq:     cover property (@(posedge clk_sys) $rose(irq_r));
endmodule : radio_spi_host_interface

// *** design/README_unused.sv ***
`timescale 1ns/1ps

// *** verif/radio_link_model.sv ***
// Purpose: Radio command-port slave seen from the SPI master
// Assumes: Mode 0, first byte after select returns radio status
// Notes:   Later bytes echo the previous byte received
`timescale 1ns/1ps
module radio_link_model #(
    parameter logic [7:0] STATUS_VAL = 8'h0E
) (
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic       slaveSelectN,
    input  wire logic       chipEnable,
    output logic            miso,
    output logic      [7:0] lastRx,
    output logic      [7:0] restarts
);
    logic [7:0] outSh;
    logic [7:0] rxSh;
    int         cnt;

    initial begin
        outSh = 8'h00;
        rxSh = 8'h00;
        cnt = 0;
        lastRx = 8'h00;
        restarts = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////////
    // Deselected line shows inverse, never a held value
    assign miso = slaveSelectN ? ~outSh[7] : outSh[7];
    // Select loads radio status for the first byte
    always @(negedge slaveSelectN) begin
        outSh = STATUS_VAL;
        cnt = 0;
    end
    // Sample mosi on rising sck, bit 7 first
    always @(posedge sck) begin
        rxSh = {rxSh[6:0], mosi};
        cnt = cnt + 1;
        if (cnt == 8) begin
            lastRx = rxSh;
        end
    end
    // Next bit after falling sck, echo after a whole byte
    always @(negedge sck) begin
        if (cnt == 8) begin
            outSh = rxSh;
            cnt = 0;
        end else begin
            outSh = {outSh[6:0], 1'b0};
        end
    end
    // Each chip-enable rise counts one restart
    always @(posedge chipEnable) begin
        restarts = restarts + 8'h01;
    end
endmodule : radio_link_model

// *** verif/test_radio_spi_host_interface.sv ***
// Purpose: Self-checking bench for the radio SPI host interface
// Assumes: Register port strobes driven on rising clk_sys
// Notes:   Row table first, then transfers, overflow, restart, reset
`timescale 1ns/1ps
module test_radio_spi_host_interface;
    typedef struct packed {
        logic [7:0] a;
        logic       w;
        logic [7:0] d;
        logic [7:0] e;
        logic [3:0] p;
    } row_t;
    logic       clk_sys;
    logic       clk_link;
    logic       rst_n;
    logic [7:0] sfrAddr;
    logic       sfrWrEn;
    logic       sfrRdEn;
    logic [7:0] sfrWrData;
    logic [7:0] sfrRdData;
    logic       miso;
    logic       sck;
    logic       mosi;
    logic       slaveSelectN;
    logic       chipEnable;
    logic       radioClkEn;
    logic       irq;
    logic [7:0] lastRx;
    logic [7:0] restarts;
    logic [7:0] v;
    int         bad_count;
    int         n_compared;
    // Pins column is {radioClkEn, slaveSelectN, chipEnable, irq}
    row_t rows [15] = '{
        '{8'hE4, 1'b0, 8'h00, 8'h01, 4'h4}, '{8'hE5, 1'b0, 8'h00, 8'h0F, 4'h4},
        '{8'hE6, 1'b0, 8'h00, 8'h03, 4'h4}, '{8'hE7, 1'b0, 8'h00, 8'h00, 4'h4},
        '{8'hE8, 1'b0, 8'h00, 8'h02, 4'h4}, '{8'hE9, 1'b0, 8'h00, 8'h00, 4'h4},
        '{8'hE5, 1'b1, 8'h0E, 8'h0E, 4'h5}, '{8'hE5, 1'b1, 8'h0D, 8'h0D, 4'h5},
        '{8'hE5, 1'b1, 8'hFB, 8'h0B, 4'h4}, '{8'hE5, 1'b1, 8'h07, 8'h07, 4'h4},
        '{8'hE6, 1'b1, 8'hFF, 8'h03, 4'h4}, '{8'hE9, 1'b1, 8'h55, 8'h00, 4'h4},
        '{8'hE8, 1'b1, 8'hFD, 8'h05, 4'hA}, '{8'hE8, 1'b1, 8'h06, 8'h06, 4'hC},
        '{8'hE5, 1'b1, 8'h0F, 8'h0F, 4'hC}};
    logic [7:0] drain [4] = '{8'h6A, 8'h11, 8'h22, 8'h33};

    radio_spi_host_interface DUT (.clk_sys(clk_sys), .rst_n(rst_n), .clk_link(clk_link),
        .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn), .sfrRdEn(sfrRdEn), .sfrWrData(sfrWrData),
        .sfrRdData(sfrRdData), .miso(miso), .sck(sck), .mosi(mosi),
        .slaveSelectN(slaveSelectN), .chipEnable(chipEnable), .radioClkEn(radioClkEn),
        .irq(irq));
    radio_link_model #(.STATUS_VAL(8'h0E)) partner (.sck(sck), .mosi(mosi),
        .slaveSelectN(slaveSelectN), .chipEnable(chipEnable), .miso(miso),
        .lastRx(lastRx), .restarts(restarts));
    ////////////////////////////////////////////////////////////////////////
    // Clocks, link clock offset in phase
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    initial begin
        clk_link = 1'b0;
        #1.7;
        forever #6 clk_link = ~clk_link;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic close_out();
        $display("Counts: %0d compared, %0d bad", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        sfrAddr <= a;
        sfrWrData <= d;
        sfrWrEn <= 1'b1;
        @(posedge clk_sys);
        sfrWrEn <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        sfrAddr <= a;
        sfrRdEn <= 1'b1;
        @(posedge clk_sys);
        sfrRdEn <= 1'b0;
        @(negedge clk_sys);
        d = sfrRdData;
    endtask : rd
    // Poll status until masked bits match, bounded
    task automatic wait_stat(input logic [7:0] m, input logic [7:0] e);
        logic [7:0] s;
        int         i;
        for (i = 0; i < 300; i++) begin
            rd(8'hE6, s);
            if ((s & m) === e) break;
        end
        if (i == 300) begin
            bad_count++;
            $display("Error status wait expected %h seen %h", e, s);
            close_out();
        end
    endtask : wait_stat
    task automatic do_reset();
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(negedge clk_sys);
        chk("pins", 8'h04, {4'h0, radioClkEn, slaveSelectN, chipEnable, irq});
        chk("sck", 8'h00, {7'h00, sck});
        $display("Test reset done");
    endtask : do_reset
    ////////////////////////////////////////////////////////////////////////
    initial begin
        bad_count = 0;
        n_compared = 0;
        rst_n = 1'b0;
        sfrAddr = 8'h00;
        sfrWrEn = 1'b0;
        sfrRdEn = 1'b0;
        sfrWrData = 8'h00;
        do_reset();
        // Register table rows
        foreach (rows[i]) begin
            if (rows[i].w) wr(rows[i].a, rows[i].d);
            rd(rows[i].a, v);
            chk("reg", rows[i].e, v);
            chk("pins", {4'h0, rows[i].p}, {4'h0, radioClkEn, slaveSelectN, chipEnable, irq});
        end
        $display("Test rows done");
        // Command transfer: status first, then echo
        wr(8'hE8, 8'h04);
        wr(8'hE7, 8'hB4);
        wait_stat(8'h04, 8'h04);
        rd(8'hE7, v);
        chk("status byte", 8'h0E, v);
        chk("sent order", 8'hB4, lastRx);
        wr(8'hE7, 8'h6A);
        wait_stat(8'h04, 8'h04);
        rd(8'hE7, v);
        chk("echo", 8'hB4, v);
        $display("Test command done");
        // Fill RX, then TX, one write dropped
        wr(8'hE7, 8'h11);
        wait_stat(8'h04, 8'h04);
        wr(8'hE7, 8'h22);
        wait_stat(8'h08, 8'h08);
        wr(8'hE7, 8'h33);
        wr(8'hE7, 8'h44);
        wr(8'hE7, 8'h55);
        wait_stat(8'h0F, 8'h0C);
        wr(8'hE5, 8'h07);
        rd(8'hE5, v);
        chk("irq full", 8'h01, {7'h00, irq});
        wr(8'hE5, 8'h0F);
        rd(8'hE5, v);
        chk("irq masked", 8'h00, {7'h00, irq});
        foreach (drain[i]) begin
            wait_stat(8'h04, 8'h04);
            rd(8'hE7, v);
            chk("drain", drain[i], v);
        end
        wait_stat(8'h0F, 8'h03);
        rd(8'hE7, v);
        chk("empty read", 8'h00, v);
        $display("Test overflow done");
        // Chip-enable toggle restarts the radio
        wr(8'hE8, 8'h05);
        rd(8'hE8, v);
        chk("restarts", 8'h02, restarts);
        $display("Test restart done");
        do_reset();
        rd(8'hE6, v);
        chk("status after reset", 8'h03, v);
        close_out();
    end
endmodule : test_radio_spi_host_interface
